// ---- hdl/alarm_severity_manager.sv ----
// Alarm classification, summary relay, thermal shutdown and system options behind an AXI4-Lite slave.
// Overview of operation
// - Each of five alarms has its own disabled, minor or major severity.
// - Any active unmasked major alarm drives the summary alarm relay output.
// - Partner switches to standby when the online unit raises summary alarm.
// - Suppressible alarms are masked only while global suppression is enabled.
// - A suppressed temperature alarm makes no alarm log event.
// - With shutdown enabled, transmit stops once temperature exceeds 85 C.
// - Transmit resumes on its own only after cooling 20 C below threshold.
// - Simulate fault raises an alarm through normal paths, transmit untouched.
// - Default output-low threshold is rated compression power minus 20 dB.
// - Default output-high threshold is rated compression power plus 1 dB.
// - A system reset request briefly mutes the transmitter.
// - Indicator LED follows its enable setting; enabled after reset.
// - Password timeout zero disables; 1 to 65535 gives minutes.
// - Echo setting chooses whether SET commands get a response.
// - Verbosity setting picks terse (enabled) or verbose responses.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
module alarm_severity_manager #(
  parameter int  MUTE_CYCLES_P   = alarm_pkg::MUTE_CYCLES,
  parameter longint MINUTE_CYCLES_P = alarm_pkg::MINUTE_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [3:0]  fault_pin,
  input  wire logic [7:0]  temp_c,
  output logic             summary_alarm,
  output logic             minor_alarm,
  output logic             tx_enable,
  output logic             led_on,
  output logic             echo_enable,
  output logic             terse_mode,
  output logic             password_expired,
  output logic [4:0]       log_event,
  output logic             log_valid
);
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  logic [9:0]                     severity;
  logic [4:0]                     suppressible;
  logic [alarm_pkg::CTL_WIDTH-1:0] control;
  logic [15:0]                    pw_timeout;
  logic signed [7:0]              p1db;
  logic signed [7:0]              out_lo_thresh;
  logic signed [7:0]              out_hi_thresh;
  logic [3:0]                     pin_sync;
  logic signed [7:0]              temp_now;
  logic                           thermal_off;
  logic [4:0]                     raw_alarm;
  logic [4:0]                     active;
  logic [4:0]                     prev_active;
  logic [4:0]                     event_sticky;
  logic                           mute;
  logic [31:0]                    mute_count;
  logic [63:0]                    minute_count;
  logic [15:0]                    minutes;
  logic                           pw_kick;

  // Pin faults: tx input low, tx input high, output low, output high detectors.
  alarm_sync #(.WIDTH(4)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (fault_pin),
    .dout    (pin_sync)
  );

  function automatic alarm_pkg::severity_e sev_of(input logic [9:0] s, input int idx);
    return alarm_pkg::severity_e'(s[idx*2 +: 2]);
  endfunction

  // ---------------- AXI4-Lite write path ----------------
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       do_write;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= alarm_pkg::REG_EVENTS);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Settings registers; only the low byte lanes that exist are honoured.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      severity     <= alarm_pkg::SEVERITY_RESET;
      suppressible <= alarm_pkg::SUPPRESS_RESET;
      control      <= alarm_pkg::CONTROL_RESET;
      pw_timeout   <= alarm_pkg::PWTIME_RESET;
      p1db         <= alarm_pkg::P1DB_RESET;
    end else if (do_write) begin
      unique case (aw_addr)
        alarm_pkg::REG_SEVERITY: begin
          if (w_strb[0]) severity[7:0] <= w_data[7:0];
          if (w_strb[1]) severity[9:8] <= w_data[9:8];
        end
        alarm_pkg::REG_SUPPRESS: if (w_strb[0]) suppressible <= w_data[4:0];
        alarm_pkg::REG_CONTROL:  if (w_strb[0]) control <= w_data[alarm_pkg::CTL_WIDTH-1:0];
        alarm_pkg::REG_PWTIME: begin
          if (w_strb[0]) pw_timeout[7:0]  <= w_data[7:0];
          if (w_strb[1]) pw_timeout[15:8] <= w_data[15:8];
        end
        alarm_pkg::REG_P1DB:     if (w_strb[0]) p1db <= w_data[7:0];
        default: ;
      endcase
    end
  end

  // Unused severity code 3 behaves as disabled; it is never a major alarm.
  assign out_lo_thresh = p1db - alarm_pkg::OUT_LO_OFFSET;
  assign out_hi_thresh = p1db + alarm_pkg::OUT_HI_OFFSET;

  // ---------------- Alarm classification ----------------
  assign temp_now = temp_c;

  always_comb begin
    raw_alarm[alarm_pkg::ALM_TEMP]   = (temp_now > alarm_pkg::SHUTDOWN_TEMP_C);
    raw_alarm[alarm_pkg::ALM_IN_LO]  = pin_sync[0];
    raw_alarm[alarm_pkg::ALM_IN_HI]  = pin_sync[1];
    raw_alarm[alarm_pkg::ALM_OUT_LO] = pin_sync[2];
    raw_alarm[alarm_pkg::ALM_OUT_HI] = pin_sync[3];
  end

  // Simulated fault enters as an extra condition on every alarm, so the normal
  // severity and suppression paths decide what it produces.
  logic [4:0] mask;
  logic [4:0] any_cond;
  genvar gi;
  generate
    for (gi = 0; gi < alarm_pkg::NUM_ALARMS; gi++) begin : g_alarm
      assign any_cond[gi] = raw_alarm[gi] || control[alarm_pkg::CTL_SIMULATE];
      assign mask[gi]     = suppressible[gi] && control[alarm_pkg::CTL_SUPPRESS];
      assign active[gi]   = any_cond[gi] && !mask[gi]
                            && (sev_of(severity, gi) inside {alarm_pkg::SEV_MINOR, alarm_pkg::SEV_MAJOR});
    end
  endgenerate

  logic next_summary;
  logic next_minor;
  always_comb begin
    next_summary = 1'b0;
    next_minor   = 1'b0;
    for (int i = 0; i < alarm_pkg::NUM_ALARMS; i++) begin
      if (active[i] && sev_of(severity, i) == alarm_pkg::SEV_MAJOR) next_summary = 1'b1;
      if (active[i] && sev_of(severity, i) == alarm_pkg::SEV_MINOR) next_minor = 1'b1;
    end
  end

  // The relay output is what the redundancy partner switches on.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      summary_alarm <= 1'b0;
      minor_alarm   <= 1'b0;
    end else begin
      summary_alarm <= next_summary;
      minor_alarm   <= next_minor;
    end
  end

  // Log events on newly active alarms; masked ones (including temperature) never log.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_active <= 5'h00;
      log_event   <= 5'h00;
      log_valid   <= 1'b0;
    end else begin
      prev_active <= active;
      log_event   <= active & ~prev_active;
      log_valid   <= |(active & ~prev_active);
    end
  end

  // Sticky copy of logged events; a new event wins over a software clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_sticky <= 5'h00;
    end else begin
      event_sticky <= ((do_write && aw_addr == alarm_pkg::REG_EVENTS && w_strb[0])
                       ? (event_sticky & ~w_data[4:0]) : event_sticky)
                      | (active & ~prev_active);
    end
  end

  // ---------------- Thermal shutdown with hysteresis ----------------
  // Uses the real temperature only, so a simulated fault never stops traffic.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thermal_off <= 1'b0;
    end else if (!control[alarm_pkg::CTL_SHUTDOWN]) begin
      thermal_off <= 1'b0;
    end else if (temp_now > alarm_pkg::SHUTDOWN_TEMP_C) begin
      thermal_off <= 1'b1;
    end else if (temp_now <= alarm_pkg::SHUTDOWN_TEMP_C - alarm_pkg::HYSTERESIS_C) begin
      thermal_off <= 1'b0;
    end
  end

  // ---------------- System reset mute ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mute       <= 1'b0;
      mute_count <= 32'h0;
    end else if (do_write && aw_addr == alarm_pkg::REG_SYSRESET && w_strb[0] && w_data[0]) begin
      mute       <= 1'b1;
      mute_count <= 32'(MUTE_CYCLES_P - 1);
    end else if (mute) begin
      if (mute_count == 32'h0) mute <= 1'b0;
      else mute_count <= mute_count - 32'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_enable   <= 1'b0;
      led_on      <= 1'b0;
      echo_enable <= 1'b0;
      terse_mode  <= 1'b0;
    end else begin
      tx_enable   <= !thermal_off && !mute;
      led_on      <= control[alarm_pkg::CTL_LED];
      echo_enable <= control[alarm_pkg::CTL_ECHO];
      terse_mode  <= control[alarm_pkg::CTL_TERSE];
    end
  end

  // ---------------- Password timeout ----------------
  // Any register access restarts the idle timer.
  assign pw_kick = do_write || (s_axi_arvalid && s_axi_arready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      minute_count     <= 64'h0;
      minutes          <= 16'h0;
      password_expired <= 1'b0;
    end else if (pw_kick || pw_timeout == 16'h0) begin
      minute_count     <= 64'h0;
      minutes          <= 16'h0;
      password_expired <= 1'b0;
    end else if (!password_expired) begin
      if (minute_count == 64'(MINUTE_CYCLES_P - 1)) begin
        minute_count <= 64'h0;
        minutes      <= minutes + 16'h1;
        if (minutes + 16'h1 == pw_timeout) password_expired <= 1'b1;
      end else begin
        minute_count <= minute_count + 64'h1;
      end
    end
  end

  // ---------------- AXI4-Lite read path ----------------
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0;
    unique case (s_axi_araddr)
      alarm_pkg::REG_SEVERITY: next_rdata = {22'h0, severity};
      alarm_pkg::REG_SUPPRESS: next_rdata = {27'h0, suppressible};
      alarm_pkg::REG_CONTROL:  next_rdata = {26'h0, control};
      alarm_pkg::REG_PWTIME:   next_rdata = {16'h0, pw_timeout};
      alarm_pkg::REG_P1DB:     next_rdata = {24'h0, p1db};
      alarm_pkg::REG_THRESH:   next_rdata = {16'h0, out_hi_thresh, out_lo_thresh};
      alarm_pkg::REG_TEMP:     next_rdata = {24'h0, temp_now};
      alarm_pkg::REG_STATUS:   next_rdata = {20'h0, password_expired, mute, thermal_off, tx_enable,
                                             minor_alarm, summary_alarm, 1'b0, active};
      alarm_pkg::REG_EVENTS:   next_rdata = {27'h0, event_sticky};
      default:                 next_rdata = 32'h0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // alarm_severity_manager

// ---- hdl/alarm_pkg.sv ----
// Package with register map, field layouts, reset values and timing constants for the alarm manager.
package alarm_pkg;
  localparam int NUM_ALARMS = 5;
  localparam int ALM_TEMP   = 0;
  localparam int ALM_IN_LO  = 1;
  localparam int ALM_IN_HI  = 2;
  localparam int ALM_OUT_LO = 3;
  localparam int ALM_OUT_HI = 4;

  typedef enum logic [1:0] {SEV_DISABLED = 2'h0, SEV_MINOR = 2'h1, SEV_MAJOR = 2'h2} severity_e;

  // Register byte offsets.
  localparam logic [7:0] REG_SEVERITY = 8'h00;
  localparam logic [7:0] REG_SUPPRESS = 8'h04;
  localparam logic [7:0] REG_CONTROL  = 8'h08;
  localparam logic [7:0] REG_SYSRESET = 8'h0C;
  localparam logic [7:0] REG_PWTIME   = 8'h10;
  localparam logic [7:0] REG_P1DB     = 8'h14;
  localparam logic [7:0] REG_THRESH   = 8'h18;
  localparam logic [7:0] REG_TEMP     = 8'h1C;
  localparam logic [7:0] REG_STATUS   = 8'h20;
  localparam logic [7:0] REG_EVENTS   = 8'h24;

  // Control register fields.
  localparam int CTL_SUPPRESS = 0;
  localparam int CTL_SIMULATE = 1;
  localparam int CTL_SHUTDOWN = 2;
  localparam int CTL_LED      = 3;
  localparam int CTL_ECHO     = 4;
  localparam int CTL_TERSE    = 5;
  localparam int CTL_WIDTH    = 6;

  // Reset values: temp/input minor, output major; shutdown and LED enabled.
  localparam logic [9:0] SEVERITY_RESET = 10'h295;
  localparam logic [4:0] SUPPRESS_RESET = 5'h1F;
  localparam logic [5:0] CONTROL_RESET  = 6'h0C;
  localparam logic [15:0] PWTIME_RESET  = 16'h0000;
  localparam logic [7:0] P1DB_RESET     = 8'h28;

  // Temperature in signed whole degrees Celsius; power in signed dBm.
  localparam logic signed [7:0] SHUTDOWN_TEMP_C = 8'sd85;
  localparam logic signed [7:0] HYSTERESIS_C    = 8'sd20;
  localparam logic signed [7:0] OUT_LO_OFFSET   = 8'sd20;
  localparam logic signed [7:0] OUT_HI_OFFSET   = 8'sd1;

  // Momentary transmit mute after a system reset request, and the password-timeout minute.
  localparam int CLK_HZ       = 10_000_000;
  localparam int MUTE_TIME_MS = 10;
  localparam int MUTE_CYCLES  = CLK_HZ / 1000 * MUTE_TIME_MS;
  localparam int MINUTE_S     = 60;
  localparam longint MINUTE_CYCLES = longint'(CLK_HZ) * MINUTE_S;
endpackage

// ---- hdl/alarm_sync.sv ----
// Three-flop input synchroniser with agreement filter for pin-level inputs.
`timescale 1ns/1ns
module alarm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // The first stage is read only by the second; a change counts once stages two and three agree.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          dout[i] <= stage3[i];
        end
      end
    end
  end
endmodule // alarm_sync

// ---- verification/alarm_severity_manager_asserts.sv ----
// Port-level checks on the alarm manager bus and outputs.
`timescale 1ns/1ns
module alarm_severity_manager_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        summary_alarm,
  input wire logic        tx_enable,
  input wire logic        led_on,
  input wire logic [4:0]  log_event,
  input wire logic        log_valid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence aw_take;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence w_take;
    s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property ((aw_take and w_take) |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_rd_answer: assert property (ar_take |-> ##[1:2] s_axi_rvalid)
    else $error("read response missing");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  a_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during response");
  a_rd_unmapped: assert property (ar_take and (s_axi_araddr > 8'h24) |->
    ##[1:2] s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_log_mask: assert property (log_valid == (log_event != 5'h00) && (log_event & $past(log_event)) == 5'h00)
    else $error("log strobe malformed or repeated");
  a_rst_quiet: assert property ($rose(aresetn) |-> !summary_alarm && !s_axi_bvalid && !log_valid)
    else $error("outputs active out of reset");
  a_led_default: assert property ($rose(aresetn) |=> led_on && tx_enable)
    else $error("led or transmit off after reset");
endmodule // alarm_severity_manager_asserts

// ---- verification/switch_ctrl_model.sv ----
// Redundancy switch controller model that watches the summary relay.
`timescale 1ns/1ns
module switch_ctrl_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic summary_alarm,
  input  wire logic rearm,
  output logic      standby_online
);
  // Nonreverting: once switched the pair stays on standby until rearmed by the operator.
  always_ff @(posedge aclk) begin
    if (!aresetn || rearm) standby_online <= 1'b0;
    else if (summary_alarm) standby_online <= 1'b1;
  end
endmodule // switch_ctrl_model

// ---- verification/alarm_severity_manager_tb_top.sv ----
// Self-checking bench for the alarm manager with a redundancy switch model.
`timescale 1ns/1ns
module alarm_severity_manager_tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rearm;
  logic        awready, wready, bvalid, arready, rvalid, standby;
  logic        summary, minor, tx_en, led, echo, terse, pw_exp, log_v;
  logic [7:0]  awaddr, araddr, temp_c;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, fault_pin;
  logic [1:0]  bresp, rresp;
  logic [4:0]  log_e;
  int          failures, samples_checked, cycles;

  alarm_severity_manager #(.MUTE_CYCLES_P(5), .MINUTE_CYCLES_P(10)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fault_pin(fault_pin),
    .temp_c(temp_c), .summary_alarm(summary), .minor_alarm(minor), .tx_enable(tx_en),
    .led_on(led), .echo_enable(echo), .terse_mode(terse), .password_expired(pw_exp),
    .log_event(log_e), .log_valid(log_v));
  switch_ctrl_model u_sw (.aclk(aclk), .aresetn(aresetn), .summary_alarm(summary), .rearm(rearm),
    .standby_online(standby));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic complete_run();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Waits are bounded only by the bench timeout, which counts a hang as a mismatch.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, (a > 8'h24) ? 2'h2 : 2'h0}, {30'h0, bresp});
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rresp", {30'h0, (a > 8'h24) ? 2'h2 : 2'h0}, {30'h0, rresp});
    chk("rdata", e, rdata);
  endtask

  task automatic t_defaults();
    rchk(alarm_pkg::REG_SEVERITY, 32'h295);
    rchk(alarm_pkg::REG_SUPPRESS, 32'h1F);
    rchk(alarm_pkg::REG_CONTROL, 32'h0C);
    rchk(alarm_pkg::REG_THRESH, 32'h2914);
    rchk(alarm_pkg::REG_PWTIME, 32'h0);
    rchk(8'h28, 32'h0);
    wr(8'h2C, 32'h1);
    wr(alarm_pkg::REG_P1DB, 32'hFB);
    rchk(alarm_pkg::REG_THRESH, 32'hFCE7);
    wr(alarm_pkg::REG_P1DB, 32'h28);
  endtask

  task automatic t_severity();
    chk("standby", 32'h0, {31'h0, standby});
    fault_pin <= 4'h8;
    cyc(8);
    chk("summary", 32'h1, {31'h0, summary});
    chk("standby", 32'h1, {31'h0, standby});
    rchk(alarm_pkg::REG_EVENTS, 32'h10);
    fault_pin <= 4'h1;
    rearm <= 1'b1;
    cyc(8);
    rearm <= 1'b0;
    chk("summary", 32'h0, {31'h0, summary});
    chk("minor", 32'h1, {31'h0, minor});
    wr(alarm_pkg::REG_SEVERITY, 32'h291);
    cyc(3);
    chk("minor", 32'h0, {31'h0, minor});
    rchk(alarm_pkg::REG_STATUS, 32'h100);
    wr(alarm_pkg::REG_SEVERITY, 32'h29D);
    cyc(3);
    rchk(alarm_pkg::REG_STATUS, 32'h100);
    wr(alarm_pkg::REG_SEVERITY, 32'h299);
    cyc(3);
    chk("summary", 32'h1, {31'h0, summary});
    chk("standby", 32'h1, {31'h0, standby});
    wr(alarm_pkg::REG_SEVERITY, 32'h295);
    fault_pin <= 4'h0;
    cyc(8);
    wr(alarm_pkg::REG_EVENTS, 32'h1F);
  endtask

  task automatic t_suppress();
    wr(alarm_pkg::REG_CONTROL, 32'h0D);
    fault_pin <= 4'h8;
    cyc(8);
    chk("summary", 32'h0, {31'h0, summary});
    wr(alarm_pkg::REG_SUPPRESS, 32'h0F);
    cyc(3);
    chk("summary", 32'h1, {31'h0, summary});
    fault_pin <= 4'h0;
    wr(alarm_pkg::REG_CONTROL, 32'h09);
    wr(alarm_pkg::REG_SUPPRESS, 32'h1F);
    cyc(8);
    wr(alarm_pkg::REG_EVENTS, 32'h1F);
    temp_c <= 8'd90;
    cyc(4);
    rchk(alarm_pkg::REG_EVENTS, 32'h0);
    chk("tx", 32'h1, {31'h0, tx_en});
    wr(alarm_pkg::REG_CONTROL, 32'h08);
    cyc(1);
    chk("log", 32'h21, {26'h0, log_v, log_e});
    cyc(2);
    rchk(alarm_pkg::REG_EVENTS, 32'h1);
    temp_c <= 8'd25;
    wr(alarm_pkg::REG_CONTROL, 32'h0C);
    wr(alarm_pkg::REG_EVENTS, 32'h1F);
  endtask

  task automatic t_thermal();
    logic [7:0] t[4] = '{8'd85, 8'd86, 8'd66, 8'd65};
    logic       e[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) begin
      temp_c <= t[i];
      cyc(4);
      chk("tx", {31'h0, e[i]}, {31'h0, tx_en});
    end
    temp_c <= 8'd25;
  endtask

  task automatic t_simulate();
    wr(alarm_pkg::REG_CONTROL, 32'h0E);
    cyc(4);
    chk("summary", 32'h1, {31'h0, summary});
    chk("tx", 32'h1, {31'h0, tx_en});
    wr(alarm_pkg::REG_CONTROL, 32'h0C);
    cyc(4);
    chk("summary", 32'h0, {31'h0, summary});
  endtask

  task automatic t_options();
    logic [5:0] v[2] = '{6'h04, 6'h3C};
    for (int i = 0; i < 2; i++) begin
      wr(alarm_pkg::REG_CONTROL, {26'h0, v[i]});
      cyc(2);
      chk("led", {31'h0, v[i][3]}, {31'h0, led});
      chk("echo", {31'h0, v[i][4]}, {31'h0, echo});
      chk("terse", {31'h0, v[i][5]}, {31'h0, terse});
    end
  endtask

  task automatic t_mute_pw();
    wr(alarm_pkg::REG_SYSRESET, 32'h1);
    cyc(1);
    chk("tx", 32'h0, {31'h0, tx_en});
    cyc(12);
    chk("tx", 32'h1, {31'h0, tx_en});
    wr(alarm_pkg::REG_PWTIME, 32'h1);
    cyc(5);
    chk("expired", 32'h0, {31'h0, pw_exp});
    cyc(20);
    chk("expired", 32'h1, {31'h0, pw_exp});
    wr(alarm_pkg::REG_PWTIME, 32'h0);
    cyc(40);
    chk("expired", 32'h0, {31'h0, pw_exp});
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, rearm} = '0;
    {awaddr, araddr, wdata, fault_pin} = '0;
    wstrb = 4'hF;
    temp_c = 8'd25;
    cycles = 0;
    cyc(5);
    aresetn <= 1'b1;
    t_defaults();
    t_severity();
    t_suppress();
    t_thermal();
    t_simulate();
    t_mute_pw();
    aresetn <= 1'b0;
    cyc(5);
    aresetn <= 1'b1;
    cyc(2);
    chk("led", 32'h1, {31'h0, led});
    t_options();
    complete_run();
  end
endmodule // alarm_severity_manager_tb_top

bind alarm_severity_manager alarm_severity_manager_asserts u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .summary_alarm(summary_alarm),
  .tx_enable(tx_enable), .led_on(led_on), .log_event(log_event), .log_valid(log_valid));
